//--- rtl/arr_pkg.sv
// Package for the analog reference and relay select block.
// Assumes one 20 MHz clock, 12-bit ADC codes (0 V/0 mA at 0, or -10 V in bipolar; full at 4095)
// and 32-bit classic Wishbone register access.
`default_nettype none
package arr_pkg;
  //////////////////////////////////////////////////////////////////////////
  // Register byte offsets
  localparam logic [7:0] ARR_REG_CTRL   = 8'h00; // Formats and relay select
  localparam logic [7:0] ARR_REG_OFFSET = 8'h04; // Input 1 offset, 0.1 %
  localparam logic [7:0] ARR_REG_SCALE  = 8'h08; // Input 1 scaling, 0.1 %
  localparam logic [7:0] ARR_REG_THRESH = 8'h0C; // Relay threshold level
  localparam logic [7:0] ARR_REG_STATUS = 8'h10; // Sticky events, W1C
  localparam logic [7:0] ARR_REG_MASK   = 8'h14; // Interrupt mask
  localparam logic [7:0] ARR_REG_REF    = 8'h18; // Processed references
  localparam logic [7:0] ARR_REG_STATE  = 8'h1C; // Live block state
  // Control field positions
  localparam int ARR_CTRL_FMT1_LSB  = 0;  // Input 1 format, 3 bits
  localparam int ARR_CTRL_FMT2_LSB  = 4;  // Input 2 format, 3 bits
  localparam int ARR_CTRL_RELAY_LSB = 8;  // Relay function, 3 bits
  // Status bit positions
  localparam int ARR_ST_TRIP  = 0;        // Trip-type signal loss
  localparam int ARR_ST_RAMP  = 1;        // Ramp-type signal loss
  localparam int ARR_ST_RELAY = 2;        // Relay contact closed
  localparam int ARR_ST_W     = 3;        // Status width
  // Reset values
  localparam logic [2:0]  ARR_FMT_RST    = 3'h0;    // Unipolar voltage
  localparam logic [2:0]  ARR_RELAY_RST  = 3'h1;    // Drive ready
  localparam logic [15:0] ARR_OFFSET_RST = 16'h0000; // 0.0 %
  localparam logic [15:0] ARR_SCALE_RST  = 16'h03E8; // 100.0 %
  localparam logic [15:0] ARR_THRESH_RST = 16'h0000;
  // Scale limits and ADC levels
  localparam int ARR_PCT_FULL   = 1000;   // 100.0 % in 0.1 % steps
  localparam int ARR_SCALE_MAX  = 5000;   // 500.0 %
  localparam int ARR_OFFSET_MAX = 5000;   // +/-500.0 %
  localparam int ARR_ADC_FULL   = 4095;   // 10 V or 20 mA
  localparam int ARR_CODE_4MA   = 819;    // 4 mA
  localparam int ARR_CODE_3MA   = 614;    // 3 mA loss level
  localparam int ARR_SPAN_4_20  = 3276;   // 16 mA span
  // Input signal formats
  typedef enum logic [2:0] {
    ARR_FMT_UNI   = 3'h0,  // 0..10 V unipolar
    ARR_FMT_BIP   = 3'h1,  // -10..10 V bipolar, input 1 only
    ARR_FMT_020   = 3'h2,  // 0..20 mA
    ARR_FMT_T420  = 3'h3,  // 4..20 mA, trip on loss
    ARR_FMT_R420  = 3'h4,  // 4..20 mA, ramp to stop on loss
    ARR_FMT_T204  = 3'h5,  // 20..4 mA, trip on loss
    ARR_FMT_R204  = 3'h6   // 20..4 mA, ramp to stop on loss
  } arr_fmt_t;
  // Drive state seen by the relay functions
  typedef struct packed {
    logic        motorEnabled; // Motor running
    logic        powerOk;      // Power applied
    logic        faultIn;      // Other drive faults
    logic [15:0] outFreq;      // Output frequency
    logic [15:0] setFreq;      // Setpoint frequency
    logic [15:0] motorCurrent; // Motor current
  } arr_drv_t;
  // Processed reference leaving the block
  typedef struct packed {
    logic       rev1;          // Input 1 commands reverse
    logic [9:0] mag1;          // Input 1 magnitude, 0.1 %
    logic [9:0] mag2;          // Input 2 magnitude, 0.1 %
  } arr_ref_t;
endpackage
`default_nettype wire

//--- rtl/arr_ref_relay.sv
// Reference conditioning, signal-loss handling and relay select.
// Assumes ADC codes and drive state come from logic on clk, so they are
// read with no synchroniser; registers sit on classic Wishbone.
//
// Notes on behaviour
// - Unipolar negative reference holds zero frequency.
// - Bipolar negative reference reverses, magnitude absolute.
// - Trip formats below 3 mA trip, loss fault.
// - Ramp formats below 3 mA ramp to stop.
// - Inverted loop: 20 mA zero, 4 mA full.
// - Input 2 formats exclude bipolar voltage.
// - Subtract signed percent offset, default zero.
// - Scale by 0..500 percent, default 100.
// - Hundred percent reference equals maximum speed.
// - Relay closes when selected function true.
// - Codes 0,1,3: enabled, ready, tripped.
// - Code 2: output equals setpoint frequency.
// - Codes 4,5: frequency/current at or above threshold.
// - Codes 6,7: frequency/current below threshold.
//
// Decided for this implementation: the placing of the registers and the Wishbone slave port.
`default_nettype none
module arr_ref_relay (
  input  wire logic              clk,
  input  wire logic              nrst,
  input  wire logic              wb_cyc_i,
  input  wire logic              wb_stb_i,
  input  wire logic              wb_we_i,
  input  wire logic [7:0]        wb_adr_i,
  input  wire logic [3:0]        wb_sel_i,
  input  wire logic [31:0]       wb_dat_i,
  output var  logic [31:0]       wb_dat_o,
  output var  logic              wb_ack_o,
  input  wire logic [11:0]       ain1Code,
  input  wire logic [11:0]       ain2Code,
  input  wire arr_pkg::arr_drv_t drv,
  output var  arr_pkg::arr_ref_t refOut,
  output var  logic              signalLossFault,
  output var  logic              rampStop,
  output var  logic              relayClose,
  output var  logic              irq
);
  //////////////////////////////////////////////////////////////////////////
  // Declarations
  typedef enum logic [2:0] {
    ARR_RUN  = 3'h1,                 // Normal reference
    ARR_RAMP = 3'h2,                 // Ramping to stop on loss
    ARR_TRIP = 3'h4                  // Tripped on loss
  } arr_state_t;
  arr_state_t state, next_state;     // Loss handling state
  arr_pkg::arr_fmt_t fmt1, fmt2;     // Input formats
  logic [2:0]  relaySel;             // Relay function code
  logic [15:0] offset;               // Signed offset, 0.1 %
  logic [15:0] scale;                // Scaling, 0.1 %
  logic [15:0] thresh;               // Relay threshold
  logic [arr_pkg::ARR_ST_W-1:0] status, mask, stSet; // Events
  logic        wbReq;                // New bus request
  logic [31:0] wmask;                // Byte lane mask
  logic [31:0] ctrlW, offW, sclW, thrW; // Merged write values
  logic signed [13:0] pct1, pct2;    // Level in 0.1 %
  logic signed [31:0] diff1, prod1, scaled1; // Offset and scale path
  logic [9:0]  mag1;                 // Input 1 magnitude
  logic        rev1;                 // Input 1 reverse
  logic        loss1, loss2;         // Loop below 3 mA
  logic        tripLoss, rampLoss;   // Loss by kind
  logic        faulted;              // Drive in fault
  logic        relayFn;              // Selected relay function

  // Level in 0.1 % of full scale for one code and format
  function automatic logic signed [13:0] lvl(input logic [11:0] c,
                                             input arr_pkg::arr_fmt_t f);
    int v;
    v = int'(c);
    case (f)
      arr_pkg::ARR_FMT_BIP:
        v = v * 2 * arr_pkg::ARR_PCT_FULL / arr_pkg::ARR_ADC_FULL
            - arr_pkg::ARR_PCT_FULL;
      arr_pkg::ARR_FMT_T420, arr_pkg::ARR_FMT_R420:
        v = (v < arr_pkg::ARR_CODE_4MA) ? 0 :
            (v - arr_pkg::ARR_CODE_4MA) * arr_pkg::ARR_PCT_FULL
            / arr_pkg::ARR_SPAN_4_20;
      arr_pkg::ARR_FMT_T204, arr_pkg::ARR_FMT_R204:
        v = (v < arr_pkg::ARR_CODE_4MA) ? arr_pkg::ARR_PCT_FULL :
            (arr_pkg::ARR_ADC_FULL - v) * arr_pkg::ARR_PCT_FULL
            / arr_pkg::ARR_SPAN_4_20;
      default:
        v = v * arr_pkg::ARR_PCT_FULL / arr_pkg::ARR_ADC_FULL;
    endcase
    return 14'(v);
  endfunction
  // Loop current under 3 mA in a loss-checked format
  function automatic logic lost(input logic [11:0] c,
                                input arr_pkg::arr_fmt_t f);
    return (f inside {arr_pkg::ARR_FMT_T420, arr_pkg::ARR_FMT_R420,
                      arr_pkg::ARR_FMT_T204, arr_pkg::ARR_FMT_R204})
           && (int'(c) < arr_pkg::ARR_CODE_3MA);
  endfunction
  // Trip-type format
  function automatic logic tripFmt(input arr_pkg::arr_fmt_t f);
    return f == arr_pkg::ARR_FMT_T420 || f == arr_pkg::ARR_FMT_T204;
  endfunction

  //////////////////////////////////////////////////////////////////////////
  // Bus decode and byte-lane merge
  assign wbReq = wb_cyc_i && wb_stb_i && !wb_ack_o;
  assign wmask = {{8{wb_sel_i[3]}}, {8{wb_sel_i[2]}},
                  {8{wb_sel_i[1]}}, {8{wb_sel_i[0]}}};
  assign ctrlW = ({21'h0, relaySel, 1'b0, fmt2, 1'b0, fmt1} & ~wmask)
               | (wb_dat_i & wmask);
  assign offW  = ({16'h0, offset} & ~wmask) | (wb_dat_i & wmask);
  assign sclW  = ({16'h0, scale} & ~wmask) | (wb_dat_i & wmask);
  assign thrW  = ({16'h0, thresh} & ~wmask) | (wb_dat_i & wmask);

  // Ack one cycle after the request, dropped the cycle after
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      wb_ack_o <= 1'b0;
    end else begin
      wb_ack_o <= wbReq;
    end
  end

  // Read data, unmapped offsets read zero
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      wb_dat_o <= 32'h0000_0000;
    end else if (wbReq && !wb_we_i) begin
      case (wb_adr_i & 8'hFC)
        arr_pkg::ARR_REG_CTRL:
          wb_dat_o <= {21'h0, relaySel, 1'b0, fmt2, 1'b0, fmt1};
        arr_pkg::ARR_REG_OFFSET: wb_dat_o <= {16'h0, offset};
        arr_pkg::ARR_REG_SCALE:  wb_dat_o <= {16'h0, scale};
        arr_pkg::ARR_REG_THRESH: wb_dat_o <= {16'h0, thresh};
        arr_pkg::ARR_REG_STATUS: wb_dat_o <= {29'h0, status};
        arr_pkg::ARR_REG_MASK:   wb_dat_o <= {29'h0, mask};
        arr_pkg::ARR_REG_REF:
          wb_dat_o <= {6'h0, refOut.mag2, 5'h0, refOut.rev1, refOut.mag1};
        arr_pkg::ARR_REG_STATE:
          wb_dat_o <= {26'h0, relayClose, irq, rampStop, signalLossFault,
                       state == ARR_RUN, faulted};
        default: wb_dat_o <= 32'h0000_0000;
      endcase
    end
  end

  //////////////////////////////////////////////////////////////////////////
  // Configuration registers, written as the request is taken
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      fmt1     <= arr_pkg::arr_fmt_t'(arr_pkg::ARR_FMT_RST);
      fmt2     <= arr_pkg::arr_fmt_t'(arr_pkg::ARR_FMT_RST);
      relaySel <= arr_pkg::ARR_RELAY_RST;
      offset   <= arr_pkg::ARR_OFFSET_RST;
      scale    <= arr_pkg::ARR_SCALE_RST;
      thresh   <= arr_pkg::ARR_THRESH_RST;
      mask     <= '0;
    end else if (wbReq && wb_we_i) begin
      case (wb_adr_i & 8'hFC)
        arr_pkg::ARR_REG_CTRL: begin
          // Unknown format codes keep the old format
          if (ctrlW[arr_pkg::ARR_CTRL_FMT1_LSB +: 3] <= 3'h6) begin
            fmt1 <= arr_pkg::arr_fmt_t'(ctrlW[arr_pkg::ARR_CTRL_FMT1_LSB +: 3]);
          end
          // Input 2 refuses bipolar and unknown codes
          if (ctrlW[arr_pkg::ARR_CTRL_FMT2_LSB +: 3] <= 3'h6 &&
              ctrlW[arr_pkg::ARR_CTRL_FMT2_LSB +: 3] != 3'h1) begin
            fmt2 <= arr_pkg::arr_fmt_t'(ctrlW[arr_pkg::ARR_CTRL_FMT2_LSB +: 3]);
          end
          relaySel <= ctrlW[arr_pkg::ARR_CTRL_RELAY_LSB +: 3];
        end
        arr_pkg::ARR_REG_OFFSET: begin
          // Out-of-range offsets are refused
          if (int'($signed(offW[15:0])) <= arr_pkg::ARR_OFFSET_MAX &&
              int'($signed(offW[15:0])) >= -arr_pkg::ARR_OFFSET_MAX) begin
            offset <= offW[15:0];
          end
        end
        arr_pkg::ARR_REG_SCALE: begin
          if (int'(sclW[15:0]) <= arr_pkg::ARR_SCALE_MAX) begin
            scale <= sclW[15:0];
          end
        end
        arr_pkg::ARR_REG_THRESH: thresh <= thrW[15:0];
        arr_pkg::ARR_REG_MASK:   mask <= wb_dat_i[arr_pkg::ARR_ST_W-1:0];
        default: ;
      endcase
    end
  end

  //////////////////////////////////////////////////////////////////////////
  // Reference path: offset, then scale, then sign policy
  always_comb begin
    pct1    = lvl(ain1Code, fmt1);
    pct2    = lvl(ain2Code, fmt2);
    diff1   = 32'(pct1) - 32'($signed(offset));
    prod1   = diff1 * 32'(scale);
    scaled1 = prod1 / arr_pkg::ARR_PCT_FULL;
    rev1    = 1'b0;
    mag1    = 10'h000;
    if (scaled1 < 0) begin
      // Unipolar formats hold zero, bipolar reverses
      if (fmt1 == arr_pkg::ARR_FMT_BIP) begin
        rev1 = 1'b1;
        mag1 = (-scaled1 >= arr_pkg::ARR_PCT_FULL) ? 10'(arr_pkg::ARR_PCT_FULL)
             : 10'(-scaled1);
      end
    end else begin
      // Full reference is maximum speed
      mag1 = (scaled1 >= arr_pkg::ARR_PCT_FULL) ? 10'(arr_pkg::ARR_PCT_FULL)
           : 10'(scaled1);
    end
  end

  //////////////////////////////////////////////////////////////////////////
  // Signal loss detection and handling state
  assign loss1    = lost(ain1Code, fmt1);
  assign loss2    = lost(ain2Code, fmt2);
  assign tripLoss = (loss1 && tripFmt(fmt1)) || (loss2 && tripFmt(fmt2));
  assign rampLoss = (loss1 && !tripFmt(fmt1)) || (loss2 && !tripFmt(fmt2));

  always_comb begin
    case (state)
      ARR_RUN:  next_state = tripLoss ? ARR_TRIP :
                             rampLoss ? ARR_RAMP : ARR_RUN;
      ARR_RAMP: next_state = tripLoss ? ARR_TRIP :
                             rampLoss ? ARR_RAMP : ARR_RUN;
      // Trip holds until software clears the loss event
      ARR_TRIP: next_state = (tripLoss || status[arr_pkg::ARR_ST_TRIP])
                             ? ARR_TRIP : ARR_RUN;
      default:  next_state = ARR_RUN;
    endcase
  end

  // Loss state register
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      state <= ARR_RUN;
    end else begin
      state <= next_state;
    end
  end

  // References and loss outputs; stop forces zero reference
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      refOut          <= '0;
      signalLossFault <= 1'b0;
      rampStop        <= 1'b0;
    end else begin
      refOut.rev1     <= (next_state == ARR_RUN) && rev1;
      refOut.mag1     <= (next_state == ARR_RUN) ? mag1 : 10'h000;
      refOut.mag2     <= (next_state == ARR_RUN && pct2 > 0) ?
                         10'(pct2) : 10'h000;
      signalLossFault <= next_state == ARR_TRIP;
      rampStop        <= next_state == ARR_RAMP;
    end
  end

  //////////////////////////////////////////////////////////////////////////
  // Relay function select
  assign faulted = (state == ARR_TRIP) || drv.faultIn;
  always_comb begin
    case (relaySel)
      3'h0: relayFn = drv.motorEnabled;
      3'h1: relayFn = drv.powerOk && !faulted;
      3'h2: relayFn = drv.outFreq == drv.setFreq;
      3'h3: relayFn = faulted;
      3'h4: relayFn = drv.outFreq >= thresh;
      3'h5: relayFn = drv.motorCurrent >= thresh;
      3'h6: relayFn = drv.outFreq < thresh;
      default: relayFn = drv.motorCurrent < thresh;
    endcase
  end

  // Relay contact drive
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      relayClose <= 1'b0;
    end else begin
      relayClose <= relayFn;
    end
  end

  //////////////////////////////////////////////////////////////////////////
  // Sticky events and interrupt; a set wins over a same-cycle clear
  assign stSet = {relayFn && !relayClose, rampLoss, tripLoss};
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      status <= '0;
      irq    <= 1'b0;
    end else begin
      if (wbReq && wb_we_i && (wb_adr_i & 8'hFC) == arr_pkg::ARR_REG_STATUS
          && wb_sel_i[0]) begin
        status <= (status & ~wb_dat_i[arr_pkg::ARR_ST_W-1:0]) | stSet;
      end else begin
        status <= status | stSet;
      end
      irq <= |(status & mask);
    end
  end

  //////////////////////////////////////////////////////////////////////////
  // Checks
  default clocking cb @(posedge clk); endclocking
  default disable iff (!nrst);
  a_uni_clamp: assert property (scaled1 < 0 &&
    fmt1 == arr_pkg::ARR_FMT_UNI |=> refOut.mag1 == 10'h000 && !refOut.rev1)
    else $error("unipolar negative reference not held at zero");
  a_bip_reverse: assert property (scaled1 < 0 &&
    fmt1 == arr_pkg::ARR_FMT_BIP && next_state == ARR_RUN
    |=> refOut.rev1 && refOut.mag1 == $past(mag1))
    else $error("bipolar negative reference did not reverse");
  a_trip_loss: assert property (tripLoss
    |=> signalLossFault && !rampStop && refOut.mag1 == 10'h000)
    else $error("trip-type loss did not trip");
  a_ramp_loss: assert property (rampLoss && !tripLoss
    && state != ARR_TRIP |=> rampStop && !signalLossFault)
    else $error("ramp-type loss did not ramp to stop");
  a_inv_full: assert property (fmt1 == arr_pkg::ARR_FMT_T204
    && ain1Code == 12'hFFF |-> pct1 == 14'sd0)
    else $error("inverted loop at 20 mA is not zero");
  a_ain2_format: assert property (fmt2 != arr_pkg::ARR_FMT_BIP)
    else $error("input 2 holds bipolar format");
  a_full_speed: assert property (fmt1 == arr_pkg::ARR_FMT_UNI
    && scaled1 >= arr_pkg::ARR_PCT_FULL && next_state == ARR_RUN
    |=> refOut.mag1 == 10'(arr_pkg::ARR_PCT_FULL))
    else $error("full reference not at maximum speed");
  a_relay_ready: assert property (relaySel == 3'h1 && drv.powerOk
    && !faulted |=> relayClose)
    else $error("relay open while drive ready");
  a_relay_limit: assert property (relaySel == 3'h6
    && drv.outFreq >= thresh |=> !relayClose)
    else $error("relay closed with frequency not below limit");
  a_irq_level: assert property (|(status & mask) |=> irq)
    else $error("unmasked event without interrupt");
  c_trip: cover property (state == ARR_RUN ##1 state == ARR_TRIP);
  c_ramp: cover property (state == ARR_RAMP ##[1:20] state == ARR_RUN);
  c_reverse: cover property (refOut.rev1 && refOut.mag1 != 10'h000);
  c_relay: cover property (!relayClose ##1 relayClose);
endmodule
`default_nettype wire

//--- test/arr_field_model.sv
// Field side model: two reference transmitters and the relay-driven load.
// Assumes the bench calls its tasks just after a rising clk edge.
`default_nettype none
module arr_field_model (
  input  wire logic              clk,
  input  wire logic              relayClose,
  output var  logic [11:0]       ain1Code,
  output var  logic [11:0]       ain2Code,
  output var  arr_pkg::arr_drv_t drv
);
  timeunit 1ns;
  timeprecision 1ns;
  int          closures;  // Contact closings seen by the load
  logic        lastRelay; // Contact state one edge ago
  //////////////////////////////////////////////////////////////////////////
  // Powered, idle drive and zero level at time zero
  initial begin
    ain1Code  = 12'h000;
    ain2Code  = 12'h000;
    drv       = {3'b010, 48'h0};
    closures  = 0;
    lastRelay = 1'b0;
  end
  // Transmitters move to new levels at once, ahead of the next edge
  task automatic setAin(input logic [11:0] a, input logic [11:0] b);
    ain1Code <= a;
    ain2Code <= b;
  endtask
  // New drive state seen by the relay functions
  task automatic setDrive(input arr_pkg::arr_drv_t d);
    drv <= d;
  endtask
  //////////////////////////////////////////////////////////////////////////
  // Load counts each closing of the contact
  always @(posedge clk) begin
    if (relayClose === 1'b1 && lastRelay !== 1'b1) begin
      closures++;
    end
    lastRelay <= relayClose;
  end
endmodule
`default_nettype wire

//--- test/testbench.sv
// Self-checking bench for the reference and relay select block.
// Assumes a 20 MHz clock and classic Wishbone with a one-cycle ack.
`default_nettype none
module testbench;
  timeunit 1ns;
  timeprecision 1ns;
  logic              clk;       // System clock
  logic              nrst;      // Async reset, active low
  logic              wbCyc;     // Bus cycle
  logic              wbStb;     // Bus strobe
  logic              wbWe;      // Bus write
  logic [7:0]        wbAdr;     // Byte address
  logic [3:0]        wbSel;     // Byte enables
  logic [31:0]       wbDatI;    // Write data
  logic [31:0]       wbDatO;    // Read data
  logic              wbAck;     // Bus answer
  logic [11:0]       ain1Code;  // Input 1 level
  logic [11:0]       ain2Code;  // Input 2 level
  arr_pkg::arr_drv_t drv;       // Drive state
  arr_pkg::arr_ref_t refOut;    // Processed references
  logic              lossFlt;   // Trip on loss
  logic              rampStop;  // Ramp on loss
  logic              relayClose;// Relay contact
  logic              irq;       // Interrupt
  int                badCount;  // Mismatches
  int                checked;   // Comparisons
  logic [31:0]       rd;        // Last read value
  arr_pkg::arr_drv_t ds;        // Drive state for relay tests
  //////////////////////////////////////////////////////////////////////////
  arr_ref_relay dut (.clk(clk), .nrst(nrst), .wb_cyc_i(wbCyc),
    .wb_stb_i(wbStb), .wb_we_i(wbWe), .wb_adr_i(wbAdr), .wb_sel_i(wbSel),
    .wb_dat_i(wbDatI), .wb_dat_o(wbDatO), .wb_ack_o(wbAck),
    .ain1Code(ain1Code), .ain2Code(ain2Code), .drv(drv), .refOut(refOut),
    .signalLossFault(lossFlt), .rampStop(rampStop),
    .relayClose(relayClose), .irq(irq));
  arr_field_model field (.clk(clk), .relayClose(relayClose),
    .ain1Code(ain1Code), .ain2Code(ain2Code), .drv(drv));
  //////////////////////////////////////////////////////////////////////////
  // Clock and time-zero values
  always #25 clk = ~clk;
  initial begin
    clk = 1'b0; nrst = 1'b0; wbCyc = 1'b0; wbStb = 1'b0; wbWe = 1'b0;
    wbAdr = 8'h00; wbSel = 4'h0; wbDatI = 32'h0; badCount = 0; checked = 0;
  end
  // Compare and report
  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    checked++;
    if (seen !== exp) begin
      badCount++;
      $display("BAD t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask
  // One classic cycle; entered just after a rising edge
  task automatic wbXfer(input logic w, input logic [7:0] a,
                        input logic [31:0] d, output logic [31:0] r);
    wbCyc <= 1'b1; wbStb <= 1'b1; wbWe <= w; wbAdr <= a;
    wbSel <= 4'hF; wbDatI <= d;
    // Hold the request until ack is seen; the watchdog ends a hang
    @(posedge clk);
    while (wbAck !== 1'b1) begin
      @(posedge clk);
    end
    r = wbDatO;
    wbCyc <= 1'b0; wbStb <= 1'b0;
    @(posedge clk);
  endtask
  task automatic wbW(input logic [7:0] a, input logic [31:0] d);
    logic [31:0] r;
    wbXfer(1'b1, a, d, r);
  endtask
  task automatic wbR(input logic [7:0] a);
    wbXfer(1'b0, a, 32'h0, rd);
  endtask
  task automatic waitClk(input int n);
    repeat (n) @(posedge clk);
  endtask
  // Input 1 path with format, offset, scale and level
  task automatic refCase(input logic [2:0] f, input logic [15:0] o,
    input logic [15:0] s, input logic [11:0] c, input logic rv,
    input logic [9:0] m);
    field.setAin(c, 12'hFFF);
    wbW(arr_pkg::ARR_REG_OFFSET, {16'h0, o});
    wbW(arr_pkg::ARR_REG_SCALE, {16'h0, s});
    wbW(arr_pkg::ARR_REG_CTRL, {21'h0, 3'h1, 5'h00, f});
    waitClk(3);
    check({21'h0, refOut.rev1, refOut.mag1}, {21'h0, rv, m});
  endtask
  // Expected relay level from the selected function
  function automatic logic relayExp(input int c, input arr_pkg::arr_drv_t d);
    case (c)
      0: return d.motorEnabled;
      1: return d.powerOk && !d.faultIn;
      2: return d.outFreq == d.setFreq;
      3: return d.faultIn;
      4: return d.outFreq >= 16'h0064;
      5: return d.motorCurrent >= 16'h0064;
      6: return d.outFreq < 16'h0064;
      default: return d.motorCurrent < 16'h0064;
    endcase
  endfunction
  // Counts, verdict, end of run
  task automatic conclude();
    $display("checked=%0d bad=%0d", checked, badCount);
    if (badCount == 0 && checked > 0) begin
      $display("STATUS OK");
    end else begin
      $display("STATUS NOT OK");
    end
    $finish;
  endtask
  // Watchdog against a hung handshake
  initial begin
    repeat (20000) @(posedge clk);
    badCount++;
    conclude();
  end
  //////////////////////////////////////////////////////////////////////////
  initial begin
    waitClk(10);
    nrst <= 1'b1;
    waitClk(3);
    check({31'h0, relayClose}, 32'h1);
    wbR(arr_pkg::ARR_REG_CTRL); check(rd, 32'h100);
    wbR(arr_pkg::ARR_REG_OFFSET); check(rd, 32'h0);
    wbR(arr_pkg::ARR_REG_SCALE); check(rd, 32'h3E8);
    wbR(8'h20); check(rd, 32'h0);
    refCase(3'h0, 16'h0000, 16'h03E8, 12'hFFF, 1'b0, 10'h3E8);
    refCase(3'h0, 16'h00C8, 16'h03E8, 12'hFFF, 1'b0, 10'h320);
    refCase(3'h0, 16'h00C8, 16'h01F4, 12'hFFF, 1'b0, 10'h190);
    refCase(3'h0, 16'h0000, 16'h07D0, 12'hFFF, 1'b0, 10'h3E8);
    refCase(3'h0, 16'h04B0, 16'h03E8, 12'hFFF, 1'b0, 10'h000);
    refCase(3'h1, 16'h0000, 16'h03E8, 12'h000, 1'b1, 10'h3E8);
    refCase(3'h1, 16'h0000, 16'h01F4, 12'h000, 1'b1, 10'h1F4);
    refCase(3'h2, 16'h0000, 16'h03E8, 12'hFFF, 1'b0, 10'h3E8);
    refCase(3'h5, 16'h0000, 16'h03E8, 12'hFFF, 1'b0, 10'h000);
    refCase(3'h6, 16'h0000, 16'h03E8, 12'h333, 1'b0, 10'h3E8);
    refCase(3'h4, 16'h0000, 16'h03E8, 12'h333, 1'b0, 10'h000);
    refCase(3'h3, 16'h0000, 16'h03E8, 12'hFFF, 1'b0, 10'h3E8);
    wbW(arr_pkg::ARR_REG_SCALE, 32'h1770);
    wbR(arr_pkg::ARR_REG_SCALE); check(rd, 32'h3E8);
    // Input 2 refuses bipolar, takes inverted trip loop
    wbW(arr_pkg::ARR_REG_CTRL, 32'h113);
    wbR(arr_pkg::ARR_REG_CTRL); check(rd, 32'h103);
    field.setAin(12'hFFF, 12'h333);
    wbW(arr_pkg::ARR_REG_CTRL, 32'h153);
    waitClk(3);
    check({22'h0, refOut.mag2}, 32'h3E8);
    wbR(arr_pkg::ARR_REG_REF); check(rd, 32'h03E8_03E8);
    // Trip loss on input 1, interrupt, relay tripped, sticky status
    wbW(arr_pkg::ARR_REG_STATUS, 32'h7);
    wbW(arr_pkg::ARR_REG_MASK, 32'h1);
    wbW(arr_pkg::ARR_REG_CTRL, 32'h303);
    field.setAin(12'h258, 12'hFFF);
    waitClk(4);
    check({31'h0, lossFlt}, 32'h1);
    check({31'h0, relayClose}, 32'h1);
    check({31'h0, irq}, 32'h1);
    check({22'h0, refOut.mag1}, 32'h0);
    wbR(arr_pkg::ARR_REG_STATE); check(rd, 32'h35);
    wbW(arr_pkg::ARR_REG_STATUS, 32'h1);
    wbR(arr_pkg::ARR_REG_STATUS); check(rd & 32'h3, 32'h1);
    field.setAin(12'hFFF, 12'hFFF);
    wbW(arr_pkg::ARR_REG_STATUS, 32'h1);
    waitClk(3);
    check({30'h0, lossFlt, irq}, 32'h0);
    // Trip loss on input 2
    wbW(arr_pkg::ARR_REG_CTRL, 32'h133);
    field.setAin(12'hFFF, 12'h258);
    waitClk(4);
    check({31'h0, lossFlt}, 32'h1);
    field.setAin(12'hFFF, 12'hFFF);
    wbW(arr_pkg::ARR_REG_STATUS, 32'h7);
    waitClk(3);
    check({31'h0, lossFlt}, 32'h0);
    // Ramp loss on upright and inverted loops
    wbW(arr_pkg::ARR_REG_CTRL, 32'h104);
    field.setAin(12'h258, 12'hFFF);
    waitClk(4);
    check({29'h0, rampStop, lossFlt, 1'b0}, 32'h4);
    check({22'h0, refOut.mag1}, 32'h0);
    wbR(arr_pkg::ARR_REG_STATUS); check(rd & 32'h3, 32'h2);
    field.setAin(12'hFFF, 12'hFFF);
    wbW(arr_pkg::ARR_REG_CTRL, 32'h106);
    field.setAin(12'h000, 12'hFFF);
    waitClk(4);
    check({31'h0, rampStop}, 32'h1);
    field.setAin(12'hFFF, 12'hFFF);
    wbW(arr_pkg::ARR_REG_STATUS, 32'h7);
    waitClk(3);
    check({31'h0, rampStop}, 32'h0);
    // Every relay function under two drive states
    wbW(arr_pkg::ARR_REG_CTRL, 32'h100);
    wbW(arr_pkg::ARR_REG_THRESH, 32'h64);
    for (int k = 0; k < 2; k++) begin
      ds = k ? {3'b011, 16'h0063, 16'h0064, 16'h0064}
             : {3'b110, 16'h0064, 16'h0064, 16'h0032};
      field.setDrive(ds);
      for (int c = 0; c < 8; c++) begin
        wbW(arr_pkg::ARR_REG_CTRL, 32'(c << 8));
        waitClk(3);
        check({31'h0, relayClose}, {31'h0, relayExp(c, ds)});
      end
    end
    check({31'h0, field.closures > 1}, 32'h1);
    conclude();
  end
endmodule
`default_nettype wire
